// ---- verif/sfb_peer.sv ----
/* Shift engine and far peer stand-in: takes tx bytes at a set pace,
   delivers rx bytes on command. Assumes the block's clock and reset. */
`timescale 1ns/100ps
module sfb_peer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       drain,
    input  wire logic [3:0] gap,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    input  wire logic       tx_avail,
    input  wire logic [7:0] tx_byte,
    output logic            rx_push,
    output logic      [7:0] rx_byte,
    output logic            tx_pop,
    output logic            got,
    output logic      [7:0] got_byte
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_push <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_push <= send;
            // Not held past the strobe, so a late sample shows
            rx_byte <= send ? send_byte : ~rx_byte;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_pop <= 1'b0;
            got <= 1'b0;
            got_byte <= 8'h00;
            cnt_r <= 4'h0;
        end else begin
            tx_pop <= 1'b0;
            got <= 1'b0;
            if (!drain || !tx_avail) begin
                cnt_r <= 4'h0;
            end else if (cnt_r == gap) begin
                tx_pop <= 1'b1;
                got <= 1'b1;
                got_byte <= tx_byte;
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ---- verif/sfb_props.sv ----
/* Checker on the sfb_top ports: bus answer timing, read data shape,
   holding of the queue and request outputs. Bound to every sfb_top. */
`timescale 1ns/100ps
module sfb_props
    import sfb_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [5:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        TX_AVAIL,
    input wire logic        TX_DMA_REQ,
    input wire logic        RX_DMA_REQ,
    input wire logic        SCK_TICK
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    AST_ACK_NEXT:
        assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    AST_ACK_PULSE:
        assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
    AST_ACK_CAUSE:
        assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack unasked");
    AST_DAT_UPPER:
        assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper data set");
    AST_RATE_B7:
        assert property (WB_ACK_O && !$past(WB_WE_I)
            && $past(WB_ADR_I[5:2]) == SFB_IDX_RATE |-> !WB_DAT_O[7])
        else $error("rate bit 7 set");
    // Without bus traffic the tx queue can only shrink
    AST_TXDMA_HOLD:
        assert property (TX_DMA_REQ && !WB_CYC_I |=> TX_DMA_REQ)
        else $error("tx request dropped");
    AST_RXDMA_HOLD:
        assert property (RX_DMA_REQ && !WB_CYC_I |=> RX_DMA_REQ)
        else $error("rx request dropped");
    AST_TXQ_NO_PUSH:
        assert property (!TX_AVAIL && !WB_CYC_I |=> !TX_AVAIL)
        else $error("tx queue grew");
    cover property ($rose(TX_DMA_REQ));
    cover property ($fell(RX_DMA_REQ));
    cover property (SCK_TICK);
endmodule
bind sfb_top sfb_props u_props (.CLK_SYS(CLK_SYS), .RST(RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .TX_AVAIL(TX_AVAIL), .TX_DMA_REQ(TX_DMA_REQ),
    .RX_DMA_REQ(RX_DMA_REQ), .SCK_TICK(SCK_TICK));

// ---- verif/testbench.sv ----
/* Self-checking bench for sfb_top with the sfb_peer stand-in.
   Assumes a 20 MHz clock and the designer's register map. */
`timescale 1ns/100ps
module testbench;
    import sfb_pkg::*;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic        drain = 0, send = 0, ack, txav, txdma, rxdma;
    logic        tick, sck, w16, irq, rxp, txpop, got;
    logic [3:0]  sel = 0, gap = 4'h3;
    logic [5:0]  adr = 0;
    logic [7:0]  sb = 0, rxb, txb, gb, b, bs[3];
    logic [31:0] dat = 0, dout, r, seed = 32'hf071;
    logic [7:0]  rq[$], tq[$];
    int          fails = 0, n_compared = 0;
    always #25 clk = ~clk;
    sfb_top dut_u (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .RX_PUSH(rxp),
        .RX_BYTE(rxb), .TX_POP(txpop), .TX_BYTE(txb), .TX_AVAIL(txav),
        .TX_DMA_REQ(txdma), .RX_DMA_REQ(rxdma), .SCK_TICK(tick),
        .SCK_OUT(sck), .WIDTH16(w16), .IRQ(irq));
    sfb_peer peer_u (.clk(clk), .rst(rst), .drain(drain), .gap(gap),
        .send(send), .send_byte(sb), .tx_avail(txav), .tx_byte(txb),
        .rx_push(rxp), .rx_byte(rxb), .tx_pop(txpop), .got(got),
        .got_byte(gb));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic flag(input logic s, input logic e);
        chk({15'h0, s}, {15'h0, e});
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {a, 2'b00};
        dat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rq.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge clk);
        send <= 1'b1;
        sb <= d;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic sck_per(input logic [2:0] p, input logic [3:0] q);
        int c;
        logic s;
        wr(SFB_IDX_RATE, {1'b0, p, q});
        repeat (2) @(posedge clk iff tick);
        s = sck;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tick !== 1'b1);
        chk(16'(c), 16'((p + 1) << q));
        flag(sck, !s);
    endtask
    task automatic test_done();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && !we)
            chk(dout[15:0], {8'h0, rq.pop_front()});
        if (got === 1'b1)
            chk({8'h0, gb}, {8'h0, tq.pop_front()});
    end
    initial begin
        #(50 * 40000);
        fails++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        flag(sck, 1'b0);
        rd(SFB_IDX_STATUS, 8'h00);
        rd(SFB_IDX_RATE, SFB_RATE_RST);
        wr(SFB_IDX_RATE, 8'hff);
        rd(SFB_IDX_RATE, 8'h7f);
        rd(4'hf, 8'h00);
        wr(SFB_IDX_CTRL, 8'h0d);
        rd(SFB_IDX_CTRL, 8'h0d);
        rd(SFB_IDX_IRQ_ST, 8'h04);
        rd(SFB_IDX_STATUS, 8'h05);
        flag(txdma, 1'b1);
        // Ninth byte meets a full queue and is dropped
        for (int i = 0; i < 9; i++) begin
            r = xs();
            wr(SFB_IDX_DL, r[7:0]);
            if (i < 8) tq.push_back(r[7:0]);
            if (i == 6) rd(SFB_IDX_STATUS, 8'h01);
            if (i == 7) flag(txdma, 1'b0);
        end
        rd(SFB_IDX_STATUS, 8'h03);
        rd(SFB_IDX_LEVEL, 8'h80);
        rd(SFB_IDX_IRQ_ST, 8'h06);
        r = xs();
        gap <= {1'b0, r[2:0]} + 4'h3;
        drain <= 1'b1;
        wait (tq.size() == 0);
        rd(SFB_IDX_STATUS, 8'h05);
        flag(txdma, 1'b1);
        wr(SFB_IDX_CTRL, 8'h15);
        wr(SFB_IDX_IRQ_CL, 8'hff);
        wr(SFB_IDX_IRQ_EN, 8'h01);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            bs[i] = r[7:0];
            push(bs[i]);
        end
        flag(rxdma, 1'b1);
        flag(irq, 1'b1);
        rd(SFB_IDX_STATUS, 8'h04);
        wr(SFB_IDX_IRQ_EN, 8'h00);
        flag(irq, 1'b0);
        wr(SFB_IDX_IRQ_EN, 8'h01);
        flag(irq, 1'b1);
        wr(SFB_IDX_IRQ_CL, 8'h01);
        flag(irq, 1'b0);
        for (int i = 0; i < 3; i++) rd(SFB_IDX_DL, bs[i]);
        flag(rxdma, 1'b0);
        rd(SFB_IDX_STATUS, 8'h05);
        wr(SFB_IDX_CTRL, 8'h17);
        flag(w16, 1'b1);
        r = xs();
        b = r[7:0];
        push(b);
        push(~b);
        rd(SFB_IDX_DH, b);
        rd(SFB_IDX_DL, ~b);
        rd(SFB_IDX_STATUS, 8'h05);
        // Queue mode off: the empty flag carries no meaning, only zero
        wr(SFB_IDX_CTRL, 8'h13);
        rd(SFB_IDX_STATUS, 8'h00);
        wr(SFB_IDX_CTRL, 8'h21);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            sck_per(r[6:4], {2'b00, r[1:0]});
        end
        sck_per(3'h7, SFB_RATE_MAX);
        wr(SFB_IDX_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        flag(sck, 1'b0);
        test_done();
    end
endmodule

// ---- verilog/sfb_mem.sv ----
/*
 * Small byte queue storage with registered read data.
 * Assumes the owner guards overflow and underflow.
 */
`timescale 1ns/100ps
module sfb_mem
    import sfb_pkg::*;
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 we,
    input  wire logic [SFB_QAW-1:0]   waddr,
    input  wire logic [7:0]           wdata,
    input  wire logic [SFB_QAW-1:0]   raddr,
    output logic      [7:0]           rdata
);
    logic [7:0] mem_r [SFB_QDEPTH];

    always_ff @(posedge CLK_SYS) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // Registered read: data lags the address by one edge
    always_ff @(posedge CLK_SYS) begin
        rdata <= mem_r[raddr];
    end
endmodule

// ---- verilog/sfb_pkg.sv ----
/*
 * Shared constants and types for the serial unit queue-flag and bit-rate
 * block. Assumes a classic Wishbone slave with 32-bit data, 8-bit
 * registers in the low byte of each word, and one 20 MHz clock.
 */
// Function
// - Tx full flag set at eight bytes
// - Tx DMA request while tx queue not full
// - Rx empty flag reflects read queue content
// - Rx DMA request while rx queue not empty
// - Power-on: nearly-empty and rx-empty read 0
// - Mode change resets status and both queues
// - Data byte reads pop the read queue
// - Bit-rate register accessible at any time
// - Bit-rate bit 7 reads zero
// - Prescaler divides by field plus one
// - Divider divides by two to field+1
// - Prescaler output feeds divider in series
// - Width bit selects 8 or 16 bit
package sfb_pkg;
    localparam logic [3:0] SFB_IDX_CTRL   = 4'h0;
    localparam logic [3:0] SFB_IDX_RATE   = 4'h1;
    localparam logic [3:0] SFB_IDX_STATUS = 4'h3;
    localparam logic [3:0] SFB_IDX_DH     = 4'h4;
    localparam logic [3:0] SFB_IDX_DL     = 4'h5;
    localparam logic [3:0] SFB_IDX_IRQ_ST = 4'h8;
    localparam logic [3:0] SFB_IDX_IRQ_EN = 4'h9;
    localparam logic [3:0] SFB_IDX_IRQ_CL = 4'ha;
    localparam logic [3:0] SFB_IDX_LEVEL  = 4'hb;

    localparam int SFB_CTRL_EN    = 0;
    localparam int SFB_CTRL_WIDTH = 1;
    localparam int SFB_CTRL_QUEUE = 2;
    localparam int SFB_CTRL_TXDMA = 3;
    localparam int SFB_CTRL_RXDMA = 4;
    localparam int SFB_CTRL_MSTR  = 5;

    localparam int SFB_ST_RXE = 0;
    localparam int SFB_ST_TXF = 1;
    localparam int SFB_ST_TNE = 2;

    localparam logic [7:0] SFB_CTRL_RST  = 8'h00;
    localparam logic [7:0] SFB_RATE_RST  = 8'h00;
    localparam logic [3:0] SFB_QUEUE_BYTES = 4'h8;
    localparam logic [3:0] SFB_TNE_BYTES = 4'h2;
    localparam logic [3:0] SFB_RATE_MAX  = 4'h8;
    localparam int         SFB_QDEPTH    = 8;
    localparam int         SFB_QAW       = 3;

    typedef struct packed {
        logic       en;
        logic       width16;
        logic       queue_on;
        logic       txdma;
        logic       rxdma;
        logic       master;
    } sfb_ctrl_t;

    typedef struct packed {
        logic       tx_nearly_empty_flag;
        logic       tx_queue_full_flag;
        logic       rx_queue_empty_flag;
    } sfb_status_t;
endpackage

// ---- verilog/sfb_top.sv ----
/*
 * Queue status flags, DMA requests and master bit-rate generator of a
 * serial unit, with a classic Wishbone register slave.
 * Assumes the shift engine runs on CLK_SYS and hands bytes over through
 * one-cycle strobes; the serial pins themselves sit outside this block.
 */
`timescale 1ns/100ps
module sfb_top
    import sfb_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        RX_PUSH,
    input  wire logic [7:0]  RX_BYTE,
    input  wire logic        TX_POP,
    output logic      [7:0]  TX_BYTE,
    output logic             TX_AVAIL,
    output logic             TX_DMA_REQ,
    output logic             RX_DMA_REQ,
    output logic             SCK_TICK,
    output logic             SCK_OUT,
    output logic             WIDTH16,
    output logic             IRQ
);
    sfb_ctrl_t        ctrl_r;
    logic [7:0]       rate_r;
    logic [7:0]       ctrl_byte;
    sfb_status_t      status;
    logic             wb_hit;
    logic             wb_wr;
    logic             wb_rd;
    logic             ack_r;
    logic [3:0]       idx;
    logic             mode_chg;
    logic             q_clr;
    logic             q_init_r;
    logic [3:0]       tx_cnt_r;
    logic [3:0]       rx_cnt_r;
    logic [SFB_QAW-1:0] tx_wp_r;
    logic [SFB_QAW-1:0] tx_rp_r;
    logic [SFB_QAW-1:0] rx_wp_r;
    logic [SFB_QAW-1:0] rx_rp_r;
    logic [7:0]       rx_q;
    logic [7:0]       tx_q;
    logic             tx_push;
    logic             tx_pop_ok;
    logic             rx_push_ok;
    logic             rx_pop;
    logic [2:0]       pre_cnt_r;
    logic             pre_tick;
    logic [8:0]       div_cnt_r;
    logic [8:0]       half_lim;
    logic [2:0]       irq_st_r;
    logic [2:0]       irq_en_r;
    logic [2:0]       ev;
    logic [2:0]       irq_clr;
    logic             txf_d_r;
    logic             rxe_d_r;
    logic [7:0]       rd_data;

    // One-hot style address match reused by the write, pop and clear strobes
    function automatic logic at(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    assign idx    = WB_ADR_I[5:2];
    assign wb_hit = WB_CYC_I && WB_STB_I && !ack_r;
    assign wb_wr  = wb_hit && WB_WE_I && WB_SEL_I[0];
    assign wb_rd  = wb_hit && !WB_WE_I;

    assign ctrl_byte = {2'b00, ctrl_r.master, ctrl_r.rxdma, ctrl_r.txdma,
                        ctrl_r.queue_on, ctrl_r.width16, ctrl_r.en};

    // Width, queue mode and enable changes all force the queue reset
    assign mode_chg = wb_wr && at(idx, SFB_IDX_CTRL) &&
        ((WB_DAT_I[SFB_CTRL_WIDTH] != ctrl_r.width16) ||
         (WB_DAT_I[SFB_CTRL_QUEUE] != ctrl_r.queue_on) ||
         (WB_DAT_I[SFB_CTRL_EN] != ctrl_r.en));
    assign q_clr = mode_chg;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_hit;
        end
    end
    assign WB_ACK_O = ack_r;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_r <= sfb_ctrl_t'(SFB_CTRL_RST[5:0]);
        end else if (wb_wr && at(idx, SFB_IDX_CTRL)) begin
            ctrl_r.en       <= WB_DAT_I[SFB_CTRL_EN];
            ctrl_r.width16  <= WB_DAT_I[SFB_CTRL_WIDTH];
            ctrl_r.queue_on <= WB_DAT_I[SFB_CTRL_QUEUE];
            ctrl_r.txdma    <= WB_DAT_I[SFB_CTRL_TXDMA];
            ctrl_r.rxdma    <= WB_DAT_I[SFB_CTRL_RXDMA];
            ctrl_r.master   <= WB_DAT_I[SFB_CTRL_MSTR];
        end
    end
    assign WIDTH16 = ctrl_r.width16;

    // No busy interlock: rate writes land whenever the bus asks
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rate_r <= SFB_RATE_RST;
        end else if (wb_wr && at(idx, SFB_IDX_RATE)) begin
            rate_r <= {1'b0, WB_DAT_I[6:0]};
        end
    end

    // Queue-reset marker: set by a mode change, not by power-on reset
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            q_init_r <= 1'b0;
        end else if (q_clr) begin
            q_init_r <= 1'b1;
        end
    end

    assign tx_push    = wb_wr && at(idx, SFB_IDX_DL) &&
                        (tx_cnt_r != SFB_QUEUE_BYTES);
    assign tx_pop_ok  = TX_POP && (tx_cnt_r != 4'h0);
    assign rx_push_ok = RX_PUSH && (rx_cnt_r != SFB_QUEUE_BYTES);
    // Low byte read pops in both widths; high byte pops too in 16-bit
    assign rx_pop = wb_rd && (rx_cnt_r != 4'h0) &&
        (at(idx, SFB_IDX_DL) ||
         (ctrl_r.width16 && at(idx, SFB_IDX_DH)));

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_cnt_r <= 4'h0;
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
        end else if (q_clr) begin
            tx_cnt_r <= 4'h0;
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_r <= tx_wp_r + 3'h1;
            end
            if (tx_pop_ok) begin
                tx_rp_r <= tx_rp_r + 3'h1;
            end
            tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop_ok};
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rx_cnt_r <= 4'h0;
            rx_wp_r  <= '0;
            rx_rp_r  <= '0;
        end else if (q_clr) begin
            rx_cnt_r <= 4'h0;
            rx_wp_r  <= '0;
            rx_rp_r  <= '0;
        end else begin
            if (rx_push_ok) begin
                rx_wp_r <= rx_wp_r + 3'h1;
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 3'h1;
            end
            rx_cnt_r <= rx_cnt_r + {3'h0, rx_push_ok} - {3'h0, rx_pop};
        end
    end

    sfb_mem u_tx_mem (
        .CLK_SYS (CLK_SYS),
        .we      (tx_push),
        .waddr   (tx_wp_r),
        .wdata   (WB_DAT_I[7:0]),
        .raddr   (tx_rp_r),
        .rdata   (tx_q)
    );

    sfb_mem u_rx_mem (
        .CLK_SYS (CLK_SYS),
        .we      (rx_push_ok),
        .waddr   (rx_wp_r),
        .wdata   (RX_BYTE),
        .raddr   (rx_rp_r),
        .rdata   (rx_q)
    );

    assign TX_BYTE  = tx_q;
    assign TX_AVAIL = tx_cnt_r != 4'h0;

    // Before any mode change the two low-going flags read 0, after it
    // they follow the queues when queue mode is on, else stay 0.
    // Two bytes are one word in 16-bit width, so one threshold serves
    always_comb begin
        status.tx_queue_full_flag = tx_cnt_r == SFB_QUEUE_BYTES;
        status.rx_queue_empty_flag = q_init_r && ctrl_r.queue_on &&
                                     (rx_cnt_r == 4'h0);
        status.tx_nearly_empty_flag = q_init_r && ctrl_r.queue_on &&
            (tx_cnt_r <= SFB_TNE_BYTES);
    end

    // DMA requests run only in queue mode with the block enabled
    assign TX_DMA_REQ = ctrl_r.queue_on && ctrl_r.txdma && ctrl_r.en &&
                        !status.tx_queue_full_flag;
    assign RX_DMA_REQ = ctrl_r.queue_on && ctrl_r.rxdma && ctrl_r.en &&
                        (rx_cnt_r != 4'h0);

    // Prescaler on the bus clock, one tick every field+1 cycles
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pre_cnt_r <= 3'h0;
        end else if (!ctrl_r.en || !ctrl_r.master || pre_tick) begin
            pre_cnt_r <= 3'h0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 3'h1;
        end
    end
    assign pre_tick = ctrl_r.en && ctrl_r.master &&
                      (pre_cnt_r == rate_r[6:4]);

    // Reserved codes clamp to the largest divisor
    assign half_lim = (rate_r[3:0] > SFB_RATE_MAX) ? 9'h100 :
                      9'(9'h1 << rate_r[3:0]);

    // Divider counts prescaler ticks only, so the ratios multiply
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            div_cnt_r <= 9'h0;
            SCK_OUT   <= 1'b0;
        end else if (!ctrl_r.en || !ctrl_r.master) begin
            div_cnt_r <= 9'h0;
            SCK_OUT   <= 1'b0;
        end else if (pre_tick) begin
            // At or past the limit: a smaller rate takes hold at once
            if (div_cnt_r >= half_lim - 9'h1) begin
                div_cnt_r <= 9'h0;
                SCK_OUT   <= !SCK_OUT;
            end else begin
                div_cnt_r <= div_cnt_r + 9'h1;
            end
        end
    end
    assign SCK_TICK = pre_tick && (div_cnt_r >= half_lim - 9'h1);

    // Interrupt sources: mode change, tx queue became full, rx queue got data
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            txf_d_r <= 1'b0;
            rxe_d_r <= 1'b1;
        end else begin
            txf_d_r <= status.tx_queue_full_flag;
            rxe_d_r <= rx_cnt_r == 4'h0;
        end
    end
    assign ev = {mode_chg, status.tx_queue_full_flag && !txf_d_r,
                 (rx_cnt_r != 4'h0) && rxe_d_r};
    assign irq_clr = (wb_wr && at(idx, SFB_IDX_IRQ_CL)) ?
                     WB_DAT_I[2:0] : 3'h0;

    // Set beats clear in the same cycle
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            irq_st_r <= 3'h0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | ev;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            irq_en_r <= 3'h0;
        end else if (wb_wr && at(idx, SFB_IDX_IRQ_EN)) begin
            irq_en_r <= WB_DAT_I[2:0];
        end
    end
    assign IRQ = |(irq_st_r & irq_en_r);

    always_comb begin
        rd_data = 8'h00;
        case (idx)
            SFB_IDX_CTRL:   rd_data = ctrl_byte;
            SFB_IDX_RATE:   rd_data = rate_r;
            SFB_IDX_STATUS: rd_data = {5'h00, status};
            SFB_IDX_DH:     rd_data = ctrl_r.width16 ? rx_q : 8'h00;
            SFB_IDX_DL:     rd_data = rx_q;
            SFB_IDX_IRQ_ST: rd_data = {5'h00, irq_st_r};
            SFB_IDX_IRQ_EN: rd_data = {5'h00, irq_en_r};
            SFB_IDX_LEVEL:  rd_data = {tx_cnt_r, rx_cnt_r};
            default:        rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= 32'h0;
        end else if (wb_rd) begin
            WB_DAT_O <= {24'h0, rd_data};
        end
    end
endmodule
